// *** rtl/isr_status.sv ***
`timescale 1ns/1ps
`default_nettype none

// Operation
// [R01] normal condition bit 0 calibration busy, bit 5 awaiting trigger
// [R02] normal condition bit 8 constant voltage, 10/11 positive/negative current limit
// [R03] abnormal condition bit 0 overvoltage, 1 overcurrent, 4 overtemperature trips
// [R04] abnormal condition bit 9 inhibit, 10 unregulated, 14 low range overflow
// [R05] standard event bits: 0 opc, 2 query, 3 device, 4 exec, 5 command, 7 power-on
// [R06] status byte and enable: bit 3 abnormal, 4 message available, 5 event summary
// [R07] bit 6 master summary or request flag by read type; bit 7 normal summary
// [R08] enabled normal events ORed onto status byte bit 7
// [R09] enabled abnormal events ORed onto status byte bit 3
// [R10] condition registers mirror live state; writes to them ignored
// [R11] rise filter lets 0-to-1 condition change set event bit
// [R12] fall filter lets 1-to-0 condition change set event bit
// [R13] event registers latch filtered transitions until read; read clears
// [R14] each group enable register masks events into the summary
// [R15] standard event register latches comm events, read-only, clear on read
// [R16] standard event enable masks bits into status byte summary
// [R17] power-on clear zeroes event enable at power-up, else value retained
// [R18] power-on bit 7 set every time the device starts
// [R19] with bit 7, enable bit 5 and no power-on clear, request service at power-up; service request enable resets to 0 here, so request waits for its write
// [R20] master summary is unlatched OR of enabled status bits; query clears nothing
// [R21] service request raises line and latches flag; serial poll returns and clears it
// [R22] message available set whenever output queue holds a byte
// [R23] reading a group event register drops its summary bit
// [R24] group registers 16 bits, unassigned zero; byte registers 8 bits
module isr_status (
  input wire logic clk,
  input wire logic reset,
  // live monitored circuits, asynchronous to clk
  input wire logic cal_busy,
  input wire logic awaiting_trigger,
  input wire logic constant_voltage_flag,
  input wire logic current_limit_positive,
  input wire logic current_limit_negative,
  input wire logic high_voltage_trip,
  input wire logic overcurrent_trip,
  input wire logic heat_trip,
  input wire logic remote_inhibit_active,
  input wire logic output_unregulated,
  input wire logic low_range_overflow,
  // communication events from the parser, one-cycle pulses; out_queue_nonempty is a level
  input wire logic op_complete,
  input wire logic query_error,
  input wire logic device_error,
  input wire logic execution_error,
  input wire logic command_error,
  input wire logic out_queue_nonempty,
  // retained store of power-on clear setting and event enable
  input wire logic nv_pon_clear,
  input wire logic [7:0] nv_comm_enable,
  // command port
  input wire logic [3:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic serial_poll,
  output logic [7:0] poll_byte,
  output logic srq,
  output logic pon_clear,
  output logic [7:0] comm_enable
);

  //////////////////////////////////////////////////////////////////////////////
  // condition capture

  logic [15:0] norm_raw;
  logic [15:0] abn_raw;
  logic [15:0] norm_sync1_ff, norm_cond_ff, norm_prev_ff;
  logic [15:0] abn_sync1_ff, abn_cond_ff, abn_prev_ff;

  always_comb begin
    norm_raw = 16'h0000;
    norm_raw[isr_pkg::NORM_CAL_BIT] = cal_busy; // R01
    norm_raw[isr_pkg::NORM_TRIG_WAIT_BIT] = awaiting_trigger; // R01
    norm_raw[isr_pkg::NORM_VREG_BIT] = constant_voltage_flag; // R02
    norm_raw[isr_pkg::NORM_CCP_BIT] = current_limit_positive; // R02
    norm_raw[isr_pkg::NORM_CCN_BIT] = current_limit_negative; // R02
    abn_raw = 16'h0000;
    abn_raw[isr_pkg::ABN_HIGH_VOLT_BIT] = high_voltage_trip; // R03
    abn_raw[isr_pkg::ABN_OC_BIT] = overcurrent_trip; // R03
    abn_raw[isr_pkg::ABN_HEAT_BIT] = heat_trip; // R03
    abn_raw[isr_pkg::ABN_INHIBIT_BIT] = remote_inhibit_active; // R04
    abn_raw[isr_pkg::ABN_UNREG_BIT] = output_unregulated; // R04
    abn_raw[isr_pkg::ABN_OVLD_BIT] = low_range_overflow; // R04
  end

  // no latching here: condition is just the synchronised live level
  always_ff @(posedge clk) begin
    if (reset) begin
      norm_sync1_ff <= 16'h0000;
      norm_cond_ff <= 16'h0000;
      norm_prev_ff <= 16'h0000;
      abn_sync1_ff <= 16'h0000;
      abn_cond_ff <= 16'h0000;
      abn_prev_ff <= 16'h0000;
    end else begin
      norm_sync1_ff <= norm_raw;
      norm_cond_ff <= norm_sync1_ff; // R10
      norm_prev_ff <= norm_cond_ff;
      abn_sync1_ff <= abn_raw;
      abn_cond_ff <= abn_sync1_ff; // R10
      abn_prev_ff <= abn_cond_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // filters and enables

  logic [15:0] norm_rise_ff, norm_fall_ff, norm_enable_ff;
  logic [15:0] abn_rise_ff, abn_fall_ff, abn_enable_ff;
  logic [7:0] sre_ff;
  logic wr_ok;

  // writes to condition, event and status byte selects fall through untouched
  assign wr_ok = reg_wr && !reset;

  always_ff @(posedge clk) begin
    if (reset) begin
      norm_rise_ff <= isr_pkg::RISE_RESET & isr_pkg::NORM_MASK;
      norm_fall_ff <= isr_pkg::FALL_RESET;
      norm_enable_ff <= isr_pkg::ENABLE_RESET;
      abn_rise_ff <= isr_pkg::RISE_RESET & isr_pkg::ABN_MASK;
      abn_fall_ff <= isr_pkg::FALL_RESET;
      abn_enable_ff <= isr_pkg::ENABLE_RESET;
      sre_ff <= isr_pkg::SRE_RESET;
    end else if (wr_ok) begin
      unique case (reg_sel)
        isr_pkg::SEL_NORM_RISE: norm_rise_ff <= reg_wdata & isr_pkg::NORM_MASK; // R11 R24
        isr_pkg::SEL_NORM_FALL: norm_fall_ff <= reg_wdata & isr_pkg::NORM_MASK; // R12 R24
        isr_pkg::SEL_NORM_ENABLE: norm_enable_ff <= reg_wdata & isr_pkg::NORM_MASK; // R14
        isr_pkg::SEL_ABN_RISE: abn_rise_ff <= reg_wdata & isr_pkg::ABN_MASK; // R11 R24
        isr_pkg::SEL_ABN_FALL: abn_fall_ff <= reg_wdata & isr_pkg::ABN_MASK; // R12 R24
        isr_pkg::SEL_ABN_ENABLE: abn_enable_ff <= reg_wdata & isr_pkg::ABN_MASK; // R14
        isr_pkg::SEL_SRQ_ENABLE: sre_ff <= reg_wdata[7:0] & isr_pkg::STB_MASK; // R06
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // group event registers

  logic [15:0] norm_event_ff, abn_event_ff;
  logic [15:0] norm_hit, abn_hit;
  logic rd_norm_event, rd_abn_event, rd_comm_event;

  assign norm_hit = (~norm_prev_ff & norm_cond_ff & norm_rise_ff)  // R11
                  | (norm_prev_ff & ~norm_cond_ff & norm_fall_ff); // R12
  assign abn_hit = (~abn_prev_ff & abn_cond_ff & abn_rise_ff)  // R11
                 | (abn_prev_ff & ~abn_cond_ff & abn_fall_ff); // R12
  assign rd_norm_event = reg_rd && reg_sel == isr_pkg::SEL_NORM_EVENT;
  assign rd_abn_event = reg_rd && reg_sel == isr_pkg::SEL_ABN_EVENT;
  assign rd_comm_event = reg_rd && reg_sel == isr_pkg::SEL_COMM_EVENT;

  // a transition in the read cycle survives the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      norm_event_ff <= 16'h0000;
      abn_event_ff <= 16'h0000;
    end else begin
      norm_event_ff <= (rd_norm_event ? 16'h0000 : norm_event_ff) | norm_hit; // R13 R23
      abn_event_ff <= (rd_abn_event ? 16'h0000 : abn_event_ff) | abn_hit; // R13 R23
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // standard event group and power-on handling

  logic [7:0] comm_event_ff, comm_enable_ff, comm_hit;
  logic pon_clear_ff, boot_ff;

  // boot_ff marks the first cycle after power-on reset release
  always_ff @(posedge clk) begin
    if (reset) begin
      boot_ff <= 1'b1;
    end else begin
      boot_ff <= 1'b0;
    end
  end

  always_comb begin
    comm_hit = 8'h00;
    comm_hit[isr_pkg::COMM_OPC_BIT] = op_complete; // R05
    comm_hit[isr_pkg::COMM_QYE_BIT] = query_error; // R05
    comm_hit[isr_pkg::COMM_DDE_BIT] = device_error; // R05
    comm_hit[isr_pkg::COMM_EXE_BIT] = execution_error; // R05
    comm_hit[isr_pkg::COMM_CME_BIT] = command_error; // R05
    comm_hit[isr_pkg::COMM_PON_BIT] = boot_ff; // R18
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      comm_event_ff <= 8'h00;
    end else begin
      comm_event_ff <= (rd_comm_event ? 8'h00 : comm_event_ff) | comm_hit; // R15
    end
  end

  // retained values are loaded after release, never under reset
  always_ff @(posedge clk) begin
    if (reset) begin
      pon_clear_ff <= 1'b1;
      comm_enable_ff <= 8'h00;
    end else if (boot_ff) begin
      pon_clear_ff <= nv_pon_clear;
      comm_enable_ff <= nv_pon_clear ? 8'h00 : (nv_comm_enable & isr_pkg::COMM_MASK); // R17 R19
    end else if (wr_ok && reg_sel == isr_pkg::SEL_COMM_ENABLE) begin
      comm_enable_ff <= reg_wdata[7:0] & isr_pkg::COMM_MASK; // R16
    end else if (wr_ok && reg_sel == isr_pkg::SEL_PON_CLEAR) begin
      pon_clear_ff <= reg_wdata[0]; // R17
    end
  end

  assign pon_clear = pon_clear_ff;
  assign comm_enable = comm_enable_ff;

  //////////////////////////////////////////////////////////////////////////////
  // status byte and service request

  logic [7:0] stb_base;
  logic mss;
  logic mss_prev_ff, rqs_ff;

  always_comb begin
    stb_base = 8'h00;
    stb_base[isr_pkg::STB_ABN_BIT] = |(abn_event_ff & abn_enable_ff); // R09 R14
    stb_base[isr_pkg::STB_MAV_BIT] = out_queue_nonempty; // R22
    stb_base[isr_pkg::STB_ESB_BIT] = |(comm_event_ff & comm_enable_ff); // R16
    stb_base[isr_pkg::STB_NORM_BIT] = |(norm_event_ff & norm_enable_ff); // R08 R14
  end

  assign mss = |(stb_base & sre_ff); // R20

  // new request only on a fresh reason; poll clear loses to a new one
  always_ff @(posedge clk) begin
    if (reset) begin
      mss_prev_ff <= 1'b0;
      rqs_ff <= 1'b0;
    end else begin
      mss_prev_ff <= mss;
      if (mss && !mss_prev_ff) begin
        rqs_ff <= 1'b1; // R21 R19
      end else if (serial_poll) begin
        rqs_ff <= 1'b0; // R21
      end
    end
  end

  assign srq = rqs_ff; // R21

  //////////////////////////////////////////////////////////////////////////////
  // read data

  logic [15:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 16'h0000;
    unique case (reg_sel)
      isr_pkg::SEL_NORM_COND: nxt_rdata = norm_cond_ff; // R10
      isr_pkg::SEL_NORM_RISE: nxt_rdata = norm_rise_ff;
      isr_pkg::SEL_NORM_FALL: nxt_rdata = norm_fall_ff;
      isr_pkg::SEL_NORM_EVENT: nxt_rdata = norm_event_ff; // R13
      isr_pkg::SEL_NORM_ENABLE: nxt_rdata = norm_enable_ff;
      isr_pkg::SEL_ABN_COND: nxt_rdata = abn_cond_ff; // R10
      isr_pkg::SEL_ABN_RISE: nxt_rdata = abn_rise_ff;
      isr_pkg::SEL_ABN_FALL: nxt_rdata = abn_fall_ff;
      isr_pkg::SEL_ABN_EVENT: nxt_rdata = abn_event_ff; // R13
      isr_pkg::SEL_ABN_ENABLE: nxt_rdata = abn_enable_ff;
      isr_pkg::SEL_COMM_EVENT: nxt_rdata = {8'h00, comm_event_ff}; // R15 R24
      isr_pkg::SEL_COMM_ENABLE: nxt_rdata = {8'h00, comm_enable_ff};
      isr_pkg::SEL_STATUS_BYTE: nxt_rdata = {8'h00, stb_base | {1'b0, mss, 6'h00}}; // R07 R20
      isr_pkg::SEL_SRQ_ENABLE: nxt_rdata = {8'h00, sre_ff}; // R06
      isr_pkg::SEL_PON_CLEAR: nxt_rdata = {15'h0000, pon_clear_ff};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  logic [15:0] rdata_ff;
  logic [7:0] poll_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      poll_ff <= 8'h00;
    end else if (serial_poll) begin
      poll_ff <= stb_base | {1'b0, rqs_ff, 6'h00}; // R07 R21
    end
  end

  assign reg_rdata = rdata_ff;
  assign poll_byte = poll_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  property p_rise_sets_event;
    @(posedge clk) disable iff (reset)
      (norm_hit != 16'h0000) |=> ((norm_event_ff & $past(norm_hit)) == $past(norm_hit));
  endproperty
  a_rise_sets_event: assert property (p_rise_sets_event) // R11
    else $error("filtered transition not latched");

  property p_abn_fall_event;
    @(posedge clk) disable iff (reset)
      (abn_prev_ff[isr_pkg::ABN_HIGH_VOLT_BIT] && !abn_cond_ff[isr_pkg::ABN_HIGH_VOLT_BIT]
       && abn_fall_ff[isr_pkg::ABN_HIGH_VOLT_BIT]) |=> abn_event_ff[isr_pkg::ABN_HIGH_VOLT_BIT];
  endproperty
  a_abn_fall_event: assert property (p_abn_fall_event) // R12
    else $error("falling overvoltage not latched");

  property p_read_clears;
    @(posedge clk) disable iff (reset)
      (rd_norm_event && norm_hit == 16'h0000) |=> (norm_event_ff == 16'h0000)
        && !stb_base[isr_pkg::STB_NORM_BIT];
  endproperty
  a_read_clears: assert property (p_read_clears) // R13
    else $error("event read did not clear");

  property p_norm_summary;
    @(posedge clk) disable iff (reset)
      (reg_rd && reg_sel == isr_pkg::SEL_STATUS_BYTE) |=>
        reg_rdata[isr_pkg::STB_NORM_BIT] == $past(|(norm_event_ff & norm_enable_ff));
  endproperty
  a_norm_summary: assert property (p_norm_summary) // R08
    else $error("normal summary mismatch");

  property p_cond_mirror;
    @(posedge clk) disable iff (reset)
      ##2 abn_cond_ff == $past(abn_raw, 2);
  endproperty
  a_cond_mirror: assert property (p_cond_mirror) // R10
    else $error("condition not tracking input");

  property p_pon_set;
    @(posedge clk)
      $fell(reset) |=> comm_event_ff[isr_pkg::COMM_PON_BIT];
  endproperty
  a_pon_set: assert property (p_pon_set) // R18
    else $error("power-on bit missing");

  property p_pon_clear;
    @(posedge clk)
      ($fell(reset) && nv_pon_clear) |=> (comm_enable_ff == 8'h00) && pon_clear_ff;
  endproperty
  a_pon_clear: assert property (p_pon_clear) // R17
    else $error("event enable not cleared at power-on");

  property p_request_on_mss;
    @(posedge clk) disable iff (reset)
      (mss && !mss_prev_ff) |=> srq;
  endproperty
  a_request_on_mss: assert property (p_request_on_mss) // R21
    else $error("service request not raised");

  property p_poll_clears;
    @(posedge clk) disable iff (reset)
      (serial_poll && !(mss && !mss_prev_ff)) |=> !srq && poll_byte[isr_pkg::STB_RQS_BIT]
        == $past(rqs_ff);
  endproperty
  a_poll_clears: assert property (p_poll_clears) // R21
    else $error("serial poll mishandled request flag");

  property p_query_mss;
    @(posedge clk) disable iff (reset)
      (reg_rd && reg_sel == isr_pkg::SEL_STATUS_BYTE && !serial_poll && !(mss && !mss_prev_ff))
        |=> reg_rdata[isr_pkg::STB_RQS_BIT] == $past(mss) && srq == $past(srq);
  endproperty
  a_query_mss: assert property (p_query_mss) // R20
    else $error("status byte query wrong");

  property p_mav;
    @(posedge clk) disable iff (reset)
      serial_poll |=> poll_byte[isr_pkg::STB_MAV_BIT] == $past(out_queue_nonempty);
  endproperty
  a_mav: assert property (p_mav) // R22
    else $error("message available mismatch");

endmodule // isr_status

`default_nettype wire

// *** rtl/isr_pkg.sv ***
`default_nettype none

package isr_pkg;

  // register select codes on the command port
  localparam logic [3:0] SEL_NORM_COND = 4'h0;
  localparam logic [3:0] SEL_NORM_RISE = 4'h1;
  localparam logic [3:0] SEL_NORM_FALL = 4'h2;
  localparam logic [3:0] SEL_NORM_EVENT = 4'h3;
  localparam logic [3:0] SEL_NORM_ENABLE = 4'h4;
  localparam logic [3:0] SEL_ABN_COND = 4'h5;
  localparam logic [3:0] SEL_ABN_RISE = 4'h6;
  localparam logic [3:0] SEL_ABN_FALL = 4'h7;
  localparam logic [3:0] SEL_ABN_EVENT = 4'h8;
  localparam logic [3:0] SEL_ABN_ENABLE = 4'h9;
  localparam logic [3:0] SEL_COMM_EVENT = 4'hA;
  localparam logic [3:0] SEL_COMM_ENABLE = 4'hB;
  localparam logic [3:0] SEL_STATUS_BYTE = 4'hC;
  localparam logic [3:0] SEL_SRQ_ENABLE = 4'hD;
  localparam logic [3:0] SEL_PON_CLEAR = 4'hE;

  // normal-operation group bit positions
  localparam int NORM_CAL_BIT = 0;
  localparam int NORM_TRIG_WAIT_BIT = 5;
  localparam int NORM_VREG_BIT = 8;
  localparam int NORM_CCP_BIT = 10;
  localparam int NORM_CCN_BIT = 11;
  localparam logic [15:0] NORM_MASK = 16'h0D21;

  // abnormal-condition group bit positions
  localparam int ABN_HIGH_VOLT_BIT = 0;
  localparam int ABN_OC_BIT = 1;
  localparam int ABN_HEAT_BIT = 4;
  localparam int ABN_INHIBIT_BIT = 9;
  localparam int ABN_UNREG_BIT = 10;
  localparam int ABN_OVLD_BIT = 14;
  localparam logic [15:0] ABN_MASK = 16'h4613;

  // standard event bits
  localparam int COMM_OPC_BIT = 0;
  localparam int COMM_QYE_BIT = 2;
  localparam int COMM_DDE_BIT = 3;
  localparam int COMM_EXE_BIT = 4;
  localparam int COMM_CME_BIT = 5;
  localparam int COMM_PON_BIT = 7;
  localparam logic [7:0] COMM_MASK = 8'hBD;

  // status byte bits
  localparam int STB_ABN_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_RQS_BIT = 6;
  localparam int STB_NORM_BIT = 7;
  localparam logic [7:0] STB_MASK = 8'hB8;

  // reset values
  localparam logic [15:0] RISE_RESET = 16'hFFFF;
  localparam logic [15:0] FALL_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [7:0] SRE_RESET = 8'h00;

endpackage

`default_nettype wire

// *** test/isr_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module isr_host (
  input wire logic clk,
  output logic [3:0] reg_sel,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  output logic serial_poll,
  input wire logic [7:0] poll_byte
);
  initial begin
    reg_sel = 4'hF;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
    serial_poll = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // strobe held over one sampling edge, then released
  task automatic wr(input logic [3:0] sel, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_sel = sel;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    // idle bus shows junk so a stale value cannot pass for data
    reg_wdata = ~d;
    reg_sel = ~sel;
  endtask

  task automatic rd(input logic [3:0] sel, output logic [15:0] d);
    @(posedge clk);
    #1;
    reg_sel = sel;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_sel = ~sel;
    d = reg_rdata;
  endtask

  // poll also clears the latched request inside the device
  task automatic poll(output logic [7:0] b);
    @(posedge clk);
    #1;
    serial_poll = 1'b1;
    @(posedge clk);
    #1;
    serial_poll = 1'b0;
    b = poll_byte;
  endtask
endmodule // isr_host

`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk, reset, mav, nv_pon_clear, srq, pon_clear;
  logic [15:0] norm_in, abn_in, reg_wdata, reg_rdata;
  logic [5:0] comm_in;
  logic [7:0] nv_comm_enable, poll_byte, comm_enable;
  logic [3:0] reg_sel;
  logic reg_wr, reg_rd, serial_poll;
  int error_cnt = 0;
  int n_compared = 0;
  int seed;
  logic [3:0] rsel [8] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'h9, 4'hD, 4'hF};
  logic [15:0] rval [8] = '{16'h0D21, 16'h0000, 16'h0000, 16'h4613, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};
  int cb [5] = '{0, 2, 3, 4, 5};

  isr_status dut (.clk(clk), .reset(reset), .cal_busy(norm_in[0]),
    .awaiting_trigger(norm_in[5]), .constant_voltage_flag(norm_in[8]),
    .current_limit_positive(norm_in[10]), .current_limit_negative(norm_in[11]),
    .high_voltage_trip(abn_in[0]), .overcurrent_trip(abn_in[1]), .heat_trip(abn_in[4]),
    .remote_inhibit_active(abn_in[9]), .output_unregulated(abn_in[10]),
    .low_range_overflow(abn_in[14]), .op_complete(comm_in[0]), .query_error(comm_in[2]),
    .device_error(comm_in[3]), .execution_error(comm_in[4]), .command_error(comm_in[5]),
    .out_queue_nonempty(mav), .nv_pon_clear(nv_pon_clear), .nv_comm_enable(nv_comm_enable),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .serial_poll(serial_poll), .poll_byte(poll_byte), .srq(srq),
    .pon_clear(pon_clear), .comm_enable(comm_enable));

  isr_host host (.clk(clk), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .serial_poll(serial_poll),
    .poll_byte(poll_byte));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic do_reset;
    @(posedge clk);
    #1;
    reset = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    // boot cycle loads the retained store
    repeat (2) @(posedge clk);
  endtask

  function automatic logic [15:0] passed(input logic [15:0] o, input logic [15:0] n,
    input logic [15:0] rf, input logic [15:0] ff, input logic [15:0] m);
    return ((~o & n & rf) | (o & ~n & ff)) & m;
  endfunction

  // one transition group: filters, events, enable, summary bit
  task automatic grp(input logic [3:0] base, input logic [15:0] m, input int sb);
    logic [15:0] old, nw, rf, ff, en, ev, got;
    for (int i = 0; i < 24; i++) begin
      rf = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
      ff = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($random(seed));
      en = (i < 2) ? 16'hFFFF : 16'($random(seed));
      nw = 16'($random(seed)) & m;
      host.wr(base + 4'h1, rf);
      host.wr(base + 4'h2, ff);
      host.wr(base + 4'h4, en);
      host.rd(base + 4'h1, got);
      chk(got, rf & m);
      host.rd(base + 4'h2, got);
      chk(got, ff & m);
      host.rd(base + 4'h4, got);
      chk(got, en & m);
      host.rd(base + 4'h3, got);
      if (base == 4'h0) begin
        old = norm_in;
        norm_in = nw;
      end else begin
        old = abn_in;
        abn_in = nw;
      end
      // two sync flops plus the event latch
      repeat (4) @(posedge clk);
      host.wr(base, ~nw);
      host.rd(base, got);
      chk(got, nw);
      ev = passed(old, nw, rf, ff, m);
      host.rd(isr_pkg::SEL_STATUS_BYTE, got);
      chk({15'h0000, got[sb]}, {15'h0000, |(ev & en)});
      host.rd(base + 4'h3, got);
      chk(got, ev);
      host.rd(base + 4'h3, got);
      chk(got, 16'h0000);
      host.rd(isr_pkg::SEL_STATUS_BYTE, got);
      chk({15'h0000, got[sb]}, 16'h0000);
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] got;
    logic [7:0] pb;
    logic [7:0] r;
    seed = 32'h61A6EB84;
    reset = 1'b1;
    norm_in = 16'h0000;
    abn_in = 16'h0000;
    comm_in = 6'h00;
    mav = 1'b0;
    nv_pon_clear = 1'b0;
    nv_comm_enable = 8'hFF;
    do_reset;
    for (int i = 0; i < 8; i++) begin
      host.rd(rsel[i], got);
      chk(got, rval[i]);
    end
    chk({7'h00, pon_clear, comm_enable}, {8'h00, isr_pkg::COMM_MASK});
    host.rd(isr_pkg::SEL_STATUS_BYTE, got);
    chk(got, 16'h0020);
    host.wr(isr_pkg::SEL_SRQ_ENABLE, 16'h0020);
    repeat (4) @(posedge clk);
    #1;
    chk({15'h0000, srq}, 16'h0001);
    host.rd(isr_pkg::SEL_STATUS_BYTE, got);
    chk(got, 16'h0060);
    host.rd(isr_pkg::SEL_SRQ_ENABLE, got);
    chk(got, 16'h0020);
    host.poll(pb);
    chk({8'h00, pb}, 16'h0060);
    chk({15'h0000, srq}, 16'h0000);
    host.poll(pb);
    chk({8'h00, pb}, 16'h0020);
    host.rd(isr_pkg::SEL_COMM_EVENT, got);
    chk(got, 16'h0080);
    host.wr(isr_pkg::SEL_COMM_EVENT, 16'hFFFF);
    host.rd(isr_pkg::SEL_COMM_EVENT, got);
    chk(got, 16'h0000);
    host.rd(isr_pkg::SEL_STATUS_BYTE, got);
    chk(got, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      r = 8'($random(seed));
      host.wr(isr_pkg::SEL_COMM_ENABLE, {8'h00, r});
      @(posedge clk);
      #1;
      comm_in = 6'(1 << cb[i]);
      @(posedge clk);
      #1;
      comm_in = 6'h00;
      host.rd(isr_pkg::SEL_STATUS_BYTE, got);
      chk({15'h0000, got[5]}, {15'h0000, |(r & 8'(1 << cb[i]))});
      host.rd(isr_pkg::SEL_COMM_ENABLE, got);
      chk(got, {8'h00, r & isr_pkg::COMM_MASK});
      chk({8'h00, comm_enable}, {8'h00, r & isr_pkg::COMM_MASK});
      host.rd(isr_pkg::SEL_COMM_EVENT, got);
      chk(got, 16'(1 << cb[i]));
    end
    host.wr(isr_pkg::SEL_SRQ_ENABLE, 16'h00FF);
    host.poll(pb);
    @(posedge clk);
    #1;
    mav = 1'b1;
    repeat (4) @(posedge clk);
    host.poll(pb);
    chk({8'h00, pb & 8'h50}, 16'h0050);
    mav = 1'b0;
    host.wr(isr_pkg::SEL_PON_CLEAR, 16'h0001);
    host.rd(isr_pkg::SEL_PON_CLEAR, got);
    chk(got, 16'h0001);
    nv_pon_clear = 1'b1;
    do_reset;
    chk({7'h00, pon_clear, comm_enable}, 16'h0100);
    host.rd(isr_pkg::SEL_COMM_EVENT, got);
    chk(got, 16'h0080);
    grp(isr_pkg::SEL_NORM_COND, isr_pkg::NORM_MASK, 7);
    grp(isr_pkg::SEL_ABN_COND, isr_pkg::ABN_MASK, 3);
    final_report;
  end
endmodule // tb_top

`default_nettype wire
